// file: logic/pftr_top.sv
// The AXI4-Lite interface to the registers is this design's own decision.
`default_nettype none

module pftr_top
	import pftr_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,

	// AXI4-Lite slave
	input wire logic [PFTR_ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [PFTR_ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,

	// cpu instruction logic
	input wire logic flash_byte_fetch_op,
	input wire logic [1:0] fetch_op_mode,
	output logic cpu_stall,
	output logic fetch_done,
	output logic [7:0] fetched_byte_latch,
	output logic [PFTR_PTR_W-1:0] flash_byte_pointer,

	// program flash word port
	output logic flash_rd_req,
	output logic [PFTR_PTR_W-2:0] flash_word_addr,
	input wire logic flash_rd_valid,
	input wire logic [PFTR_WORD_W-1:0] flash_rd_data
);

	// ==========================================================
	// state
	typedef struct packed {
		pftr_state_e state;
		logic [PFTR_PTR_W-1:0] ptr;
		logic [PFTR_PTR_W-1:0] fetch_addr;
		logic [PFTR_PTR_W-1:0] ptr_after;
		logic [7:0] latch;
		logic flash_req;
		logic stall;
		logic done;
		logic [PFTR_ADDR_W-1:0] awaddr;
		logic aw_got;
		logic awready;
		logic [7:0] wdata;
		logic wstrb0;
		logic w_got;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} pftr_state_s;

	pftr_state_s state_reg;
	pftr_state_s state_next;

	logic [PFTR_PTR_W-1:0] step_fetch;
	logic [PFTR_PTR_W-1:0] step_after;
	logic [7:0] sel_byte;
	logic [2:0] wr_dec;
	logic [2:0] rd_dec;

	// ==========================================================
	// helpers
	pftr_ptr_step u_step (
		.ptr(state_reg.ptr),
		.mode(pftr_mode_e'(fetch_op_mode)),
		.fetch_addr(step_fetch),
		.ptr_after(step_after)
	);

	pftr_byte_select u_sel (
		.word(flash_rd_data),
		.byte_lsb(state_reg.fetch_addr[0]),
		.byte_out(sel_byte)
	);

	assign wr_dec = pftr_decode(state_reg.awaddr);
	assign rd_dec = pftr_decode(s_axi_araddr);

	// ==========================================================
	// next state
	always_comb begin
		state_next = state_reg;
		state_next.done = 1'b0;

		// write address and data, taken in either order
		if (state_reg.awready && s_axi_awvalid) begin
			state_next.awaddr = s_axi_awaddr;
			state_next.aw_got = 1'b1;
			state_next.awready = 1'b0;
		end
		if (state_reg.wready && s_axi_wvalid) begin
			state_next.wdata = s_axi_wdata[7:0];
			state_next.wstrb0 = s_axi_wstrb[0];
			state_next.w_got = 1'b1;
			state_next.wready = 1'b0;
		end
		if (state_reg.aw_got && state_reg.w_got && !state_reg.bvalid) begin
			state_next.bvalid = 1'b1;
			state_next.bresp = wr_dec[2] ? PFTR_RESP_OKAY : PFTR_RESP_SLVERR;
			if (wr_dec[2] && state_reg.wstrb0) begin
				case (wr_dec[1:0])
					2'h0: state_next.latch = state_reg.wdata;
					2'h1: state_next.ptr[7:0] = state_reg.wdata;
					2'h2: begin
						state_next.ptr[15:PFTR_HIGH_LSB] = state_reg.wdata;
					end
					2'h3: begin
						// upper part holds bits 21:16
						state_next.ptr[21:PFTR_UPPER_LSB] =
							state_reg.wdata[5:0];
					end
					default: state_next.latch = state_reg.latch;
				endcase
			end
		end
		if (state_reg.bvalid && s_axi_bready) begin
			state_next.bvalid = 1'b0;
			state_next.aw_got = 1'b0;
			state_next.w_got = 1'b0;
			state_next.awready = 1'b1;
			state_next.wready = 1'b1;
		end

		// read channel
		if (state_reg.arready && s_axi_arvalid) begin
			state_next.arready = 1'b0;
			state_next.rvalid = 1'b1;
			state_next.rresp = rd_dec[2] ? PFTR_RESP_OKAY : PFTR_RESP_SLVERR;
			state_next.rdata = 32'h00000000;
			if (rd_dec[2]) begin
				case (rd_dec[1:0])
					2'h0: state_next.rdata[7:0] = state_reg.latch;
					2'h1: state_next.rdata[7:0] = state_reg.ptr[7:0];
					2'h2: state_next.rdata[7:0] = state_reg.ptr[15:8];
					2'h3: state_next.rdata[5:0] = state_reg.ptr[21:16];
					default: state_next.rdata = 32'h00000000;
				endcase
			end
		end
		if (state_reg.rvalid && s_axi_rready) begin
			state_next.rvalid = 1'b0;
			state_next.arready = 1'b1;
		end

		// ======================================================
		// fetch sequence, overrides a bus write in the same cycle
		case (state_reg.state)
			PFTR_IDLE: begin
				if (flash_byte_fetch_op) begin
					state_next.fetch_addr = step_fetch;
					state_next.ptr_after = step_after;
					state_next.ptr = step_fetch;
					state_next.flash_req = 1'b1;
					state_next.stall = 1'b1;
					state_next.state = PFTR_FETCH;
				end
			end
			PFTR_FETCH: begin
				if (flash_rd_valid) begin
					state_next.latch = sel_byte;
					state_next.ptr = state_reg.ptr_after;
					state_next.flash_req = 1'b0;
					// released with the byte already latched
					state_next.stall = 1'b0;
					state_next.done = 1'b1;
					state_next.state = PFTR_IDLE;
				end
			end
			default: begin
				state_next.flash_req = 1'b0;
				state_next.stall = 1'b0;
				state_next.state = PFTR_IDLE;
			end
		endcase
	end

	// ==========================================================
	// registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg.state <= PFTR_IDLE;
			state_reg.ptr <= PFTR_PTR_RST;
			state_reg.fetch_addr <= PFTR_PTR_RST;
			state_reg.ptr_after <= PFTR_PTR_RST;
			state_reg.latch <= PFTR_LATCH_RST;
			state_reg.flash_req <= 1'b0;
			state_reg.stall <= 1'b0;
			state_reg.done <= 1'b0;
			state_reg.awaddr <= 16'h0000;
			state_reg.aw_got <= 1'b0;
			state_reg.awready <= 1'b1;
			state_reg.wdata <= 8'h00;
			state_reg.wstrb0 <= 1'b0;
			state_reg.w_got <= 1'b0;
			state_reg.wready <= 1'b1;
			state_reg.bvalid <= 1'b0;
			state_reg.bresp <= PFTR_RESP_OKAY;
			state_reg.arready <= 1'b1;
			state_reg.rvalid <= 1'b0;
			state_reg.rdata <= 32'h00000000;
			state_reg.rresp <= PFTR_RESP_OKAY;
		end else begin
			state_reg <= state_next;
		end
	end

	// ==========================================================
	// outputs
	assign s_axi_awready = state_reg.awready;
	assign s_axi_wready = state_reg.wready;
	assign s_axi_bvalid = state_reg.bvalid;
	assign s_axi_bresp = state_reg.bresp;
	assign s_axi_arready = state_reg.arready;
	assign s_axi_rvalid = state_reg.rvalid;
	assign s_axi_rdata = state_reg.rdata;
	assign s_axi_rresp = state_reg.rresp;
	assign cpu_stall = state_reg.stall;
	assign fetch_done = state_reg.done;
	assign fetched_byte_latch = state_reg.latch;
	assign flash_byte_pointer = state_reg.ptr;
	assign flash_rd_req = state_reg.flash_req;
	assign flash_word_addr = state_reg.fetch_addr[PFTR_PTR_W-1:1];

endmodule // pftr_top

`default_nettype wire

// file: common/pftr_pkg.sv
// Function
// - each fetch moves one byte into latch
// - 22-bit byte pointer, upper part bits 21:16
// - pointer updated per fetch variant
// - cpu stalled during fetch, released after
// - byte valid by next instruction cycle
// - pointer lsb picks high or low byte
`default_nettype none

package pftr_pkg;

	// ==========================================================
	// widths
	localparam int PFTR_PTR_W = 22;
	localparam int PFTR_ADDR_W = 16;
	localparam int PFTR_WORD_W = 16;

	// ==========================================================
	// register indices, byte address is four times the index
	localparam logic [11:0] PFTR_IDX_LATCH = 12'hFF5;
	localparam logic [11:0] PFTR_IDX_PTR_LOW = 12'hFF6;
	localparam logic [11:0] PFTR_IDX_PTR_HIGH = 12'hFF7;
	localparam logic [11:0] PFTR_IDX_PTR_UPPER = 12'hFF8;

	// ==========================================================
	// field positions and reset values
	localparam int PFTR_UPPER_LSB = 16;
	localparam int PFTR_HIGH_LSB = 8;
	localparam logic [7:0] PFTR_LATCH_RST = 8'h00;
	localparam logic [21:0] PFTR_PTR_RST = 22'h000000;
	localparam logic [1:0] PFTR_RESP_OKAY = 2'h0;
	localparam logic [1:0] PFTR_RESP_SLVERR = 2'h2;

	// ==========================================================
	// types
	typedef enum logic [1:0] {
		PFTR_OP_KEEP,
		PFTR_OP_POSTINC,
		PFTR_OP_POSTDEC,
		PFTR_OP_PREINC
	} pftr_mode_e;

	typedef enum logic {
		PFTR_IDLE,
		PFTR_FETCH
	} pftr_state_e;

	// ==========================================================
	// address decode: bit 2 hit, bits 1:0 register select
	function automatic logic [2:0] pftr_decode(
		input logic [PFTR_ADDR_W-1:0] addr
	);
		logic [13:0] idx;
		idx = addr[PFTR_ADDR_W-1:2];
		if (idx == {2'h0, PFTR_IDX_LATCH}) begin
			pftr_decode = 3'h4;
		end else if (idx == {2'h0, PFTR_IDX_PTR_LOW}) begin
			pftr_decode = 3'h5;
		end else if (idx == {2'h0, PFTR_IDX_PTR_HIGH}) begin
			pftr_decode = 3'h6;
		end else if (idx == {2'h0, PFTR_IDX_PTR_UPPER}) begin
			pftr_decode = 3'h7;
		end else begin
			pftr_decode = 3'h0;
		end
	endfunction

endpackage

`default_nettype wire

// file: logic/pftr_ptr_step.sv
`default_nettype none

module pftr_ptr_step
	import pftr_pkg::*;
(
	input wire logic [PFTR_PTR_W-1:0] ptr,
	input wire pftr_mode_e mode,
	output logic [PFTR_PTR_W-1:0] fetch_addr,
	output logic [PFTR_PTR_W-1:0] ptr_after
);

	logic [PFTR_PTR_W-1:0] ptr_inc;
	logic [PFTR_PTR_W-1:0] ptr_dec;

	// wraps within 22 bits
	assign ptr_inc = ptr + 22'h000001;
	assign ptr_dec = ptr - 22'h000001;

	always_comb begin
		fetch_addr = ptr;
		ptr_after = ptr;
		case (mode)
			PFTR_OP_POSTINC: ptr_after = ptr_inc;
			PFTR_OP_POSTDEC: ptr_after = ptr_dec;
			PFTR_OP_PREINC: begin
				fetch_addr = ptr_inc;
				ptr_after = ptr_inc;
			end
			default: ptr_after = ptr;
		endcase
	end

endmodule // pftr_ptr_step

`default_nettype wire

// file: logic/pftr_byte_select.sv
`default_nettype none

module pftr_byte_select
	import pftr_pkg::*;
(
	input wire logic [PFTR_WORD_W-1:0] word,
	input wire logic byte_lsb,
	output logic [7:0] byte_out
);

	// lsb set picks the high byte of the word
	assign byte_out = byte_lsb ? word[15:8] : word[7:0];

endmodule // pftr_byte_select

`default_nettype wire

// file: test/pftr_chk.sv
`default_nettype none

module pftr_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic flash_byte_fetch_op,
	input wire logic [1:0] fetch_op_mode,
	input wire logic cpu_stall,
	input wire logic fetch_done,
	input wire logic [7:0] fetched_byte_latch,
	input wire logic [21:0] flash_byte_pointer,
	input wire logic flash_rd_req,
	input wire logic [20:0] flash_word_addr,
	input wire logic flash_rd_valid,
	input wire logic [15:0] flash_rd_data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic take;
	logic [1:0] md_reg;
	logic [7:0] sel;
	logic [21:0] step;
	assign take = flash_byte_fetch_op && !cpu_stall;
	assign sel = flash_byte_pointer[0] ? flash_rd_data[15:8] :
		flash_rd_data[7:0];
	assign step = {{21{md_reg == 2'h2}}, md_reg inside {2'h1, 2'h2}};
	// mode held for the post update
	always_ff @(posedge aclk) begin
		if (take) begin
			md_reg <= fetch_op_mode;
		end
	end
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence s_ans;
		cpu_stall && flash_rd_valid;
	endsequence
	// ==========================================================
	// fetch sequence
	a_stall_take: assert property (
		take |=> cpu_stall && flash_rd_req) else $error("no stall");
	a_stall_hold: assert property (
		cpu_stall && !flash_rd_valid |=> cpu_stall && flash_rd_req)
		else $error("stall dropped");
	a_resume_now: assert property (
		s_ans |=> !cpu_stall && !flash_rd_req && fetch_done ##1 !fetch_done)
		else $error("no resume");
	a_latch_byte: assert property (
		s_ans |=> fetched_byte_latch == $past(sel)) else $error("bad byte");
	a_ptr_post: assert property (
		s_ans |=> flash_byte_pointer == $past(flash_byte_pointer) + step)
		else $error("bad post update");
	a_ptr_pre: assert property (
		take && fetch_op_mode == 2'h3 |=>
		flash_byte_pointer == $past(flash_byte_pointer) + 22'h1)
		else $error("bad pre increment");
	a_word_addr: assert property (
		cpu_stall |-> flash_word_addr == flash_byte_pointer[21:1])
		else $error("bad word address");
	a_done_cause: assert property (
		fetch_done |-> $past(cpu_stall) && $past(flash_rd_valid))
		else $error("stray done");
endmodule // pftr_chk

bind pftr_top pftr_chk u_chk (
	.aclk(aclk),
	.aresetn(aresetn),
	.flash_byte_fetch_op(flash_byte_fetch_op),
	.fetch_op_mode(fetch_op_mode),
	.cpu_stall(cpu_stall),
	.fetch_done(fetch_done),
	.fetched_byte_latch(fetched_byte_latch),
	.flash_byte_pointer(flash_byte_pointer),
	.flash_rd_req(flash_rd_req),
	.flash_word_addr(flash_word_addr),
	.flash_rd_valid(flash_rd_valid),
	.flash_rd_data(flash_rd_data)
);

`default_nettype wire

// file: test/pftr_flash_mdl.sv
`default_nettype none

module pftr_flash_mdl (
	input wire logic aclk,
	input wire logic [3:0] lat,
	input wire logic flash_rd_req,
	input wire logic [20:0] flash_word_addr,
	output logic flash_rd_valid,
	output logic [15:0] flash_rd_data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt = 4'h0;
	logic valid_q = 1'h0;
	logic [15:0] data_q = 16'h0;
	assign flash_rd_valid = valid_q;
	assign flash_rd_data = data_q;
	// ==========================================================
	// word answer after lat extra cycles
	always @(posedge aclk) begin
		if (flash_rd_req && !valid_q && cnt >= lat) begin
			valid_q <= 1'h1;
			data_q <= {flash_word_addr[7:0] ^ flash_word_addr[20:13],
				flash_word_addr[15:8]};
			cnt <= 4'h0;
		end else begin
			valid_q <= 1'h0;
			// data toggles so a stale word never looks valid
			data_q <= ~data_q;
			cnt <= flash_rd_req ? cnt + 4'h1 : 4'h0;
		end
	end
endmodule // pftr_flash_mdl

`default_nettype wire

// file: test/tb.sv
`default_nettype none

module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [15:0] s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic flash_byte_fetch_op = 1'h0;
	logic [1:0] fetch_op_mode = 2'h0;
	logic [3:0] lat = 4'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, cpu_stall, fetch_done, flash_rd_req, flash_rd_valid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [7:0] fetched_byte_latch, lb;
	logic [21:0] flash_byte_pointer, p;
	logic [20:0] flash_word_addr;
	logic [15:0] flash_rd_data;
	int fail_count = 0, cmp_count = 0;

	pftr_top DUT (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awprot(3'h0),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arprot(3'h0),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.flash_byte_fetch_op(flash_byte_fetch_op),
		.fetch_op_mode(fetch_op_mode),
		.cpu_stall(cpu_stall),
		.fetch_done(fetch_done),
		.fetched_byte_latch(fetched_byte_latch),
		.flash_byte_pointer(flash_byte_pointer),
		.flash_rd_req(flash_rd_req),
		.flash_word_addr(flash_word_addr),
		.flash_rd_valid(flash_rd_valid),
		.flash_rd_data(flash_rd_data)
	);
	pftr_flash_mdl u_flash (.aclk, .lat, .flash_rd_req, .flash_word_addr,
		.flash_rd_valid, .flash_rd_data);

	always #5 aclk = ~aclk;

	// ==========================================================
	// tasks
	task automatic conclude();
		$display("checks %0d failures %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d,
		input logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1);
		s_axi_bready <= 1'h0;
		chk({30'h0, s_axi_bresp}, {30'h0, r});
	endtask

	task automatic rd(input logic [15:0] a, input logic [31:0] e,
		input logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1);
		s_axi_rready <= 1'h0;
		chk(s_axi_rdata, e);
		chk({30'h0, s_axi_rresp}, {30'h0, r});
	endtask

	task automatic setp(input logic [21:0] v);
		wr(16'h3FD8, v[7:0], 2'h0);
		wr(16'h3FDC, v[15:8], 2'h0);
		wr(16'h3FE0, {2'h3, v[21:16]}, 2'h0);
		rd(16'h3FE0, {26'h0, v[21:16]}, 2'h0);
		p = v;
	endtask

	task automatic fetch(input logic [1:0] m, input logic [3:0] l);
		logic [21:0] fa;
		logic [15:0] w;
		fa = m == 2'h3 ? p + 22'h1 : p;
		p = fa + (m == 2'h1 ? 22'h1 : m == 2'h2 ? 22'h3FFFFF : 22'h0);
		w = {fa[8:1] ^ fa[21:14], fa[16:9]};
		@(posedge aclk);
		flash_byte_fetch_op <= 1'h1;
		fetch_op_mode <= m;
		lat <= l;
		@(posedge aclk);
		flash_byte_fetch_op <= 1'h0;
		do begin
			@(posedge aclk);
		end while (fetch_done !== 1'h1);
		lb = fa[0] ? w[15:8] : w[7:0];
		chk({24'h0, fetched_byte_latch}, {24'h0, lb});
		chk({10'h0, flash_byte_pointer}, {10'h0, p});
	endtask

	// ==========================================================
	// sequence
	initial begin
		void'($urandom(88));
		repeat (10) @(posedge aclk);
		aresetn <= 1'h1;
		for (int i = 0; i < 4; i++)
			rd(16'h3FD4 + 16'(i * 4), 32'h0, 2'h0);
		rd(16'h0100, 32'h0, 2'h2);
		wr(16'h0100, 8'h11, 2'h2);
		wr(16'h3FD4, 8'hA5, 2'h0);
		rd(16'h3FD4, 32'hA5, 2'h0);
		// strobe bit 0 low: answered okay, latch untouched
		s_axi_wstrb <= 4'hE;
		wr(16'h3FD4, 8'h5A, 2'h0);
		s_axi_wstrb <= 4'hF;
		rd(16'h3FD4, 32'hA5, 2'h0);
		setp(22'h3FFFFF);
		fetch(2'h1, 4'h0);
		fetch(2'h2, 4'h3);
		fetch(2'h3, 4'h1);
		fetch(2'h0, 4'h5);
		repeat (40) begin
			if ($urandom % 4 == 0)
				setp(22'($urandom));
			fetch(2'($urandom), 4'($urandom % 6));
		end
		rd(16'h3FD8, {24'h0, p[7:0]}, 2'h0);
		rd(16'h3FD4, {24'h0, lb}, 2'h0);
		conclude();
	end

	initial begin
		#100000;
		fail_count++;
		conclude();
	end
endmodule // tb

`default_nettype wire
